/* pwr_seq_defs.svh */
// timing counts and encodings for the power state sequencer
`ifndef PWR_SEQ_DEFS_SVH
`define PWR_SEQ_DEFS_SVH
`define CLOCK_FREQ_HZ          40000000
`define PLL_SETTLE_TIME_US     250
`define PLL_SETTLE_CYCLES      (`PLL_SETTLE_TIME_US * (`CLOCK_FREQ_HZ / 1000000))
`define WAKE_TIMER_WIDTH       16
`define WAKE_TIMER_RESET       16'h0100
`define STEP_CYCLES            4'h4
`define PSTATE_SLEEP           4'h0
`define PSTATE_SNOOZE          4'h1
`define PSTATE_LOW_CLOCK       4'h2
`define PSTATE_DEVICE          4'h3
`define PSTATE_HOST            4'h4
`define PSTATE_ALL             4'h5
`endif

/* pwr_seq_pkg.sv */
// types of the power state sequencer
package pwr_seq_pkg;
    typedef enum logic [2:0] {
        ST_IDLE       = 3'b000,
        ST_STOP_FAST  = 3'b001,
        ST_STOP_SLOW  = 3'b011,
        ST_STOP_CLK   = 3'b010,
        ST_STOP_OSC   = 3'b110,
        ST_OSC_SETTLE = 3'b111,
        ST_PLL_SETTLE = 3'b101,
        ST_FAST_ON    = 3'b100
    } seq_phase_t;

    typedef struct packed {
        seq_phase_t  phase;
        logic [3:0]  power_state_field;
        logic [3:0]  target;
        logic        target_host;
        logic        active_role_indicator;
        logic [6:0]  pending;
        logic        transition_finished_flag;
        logic [15:0] count;
        logic        osc_on;
        logic        osc_clk_gate;
        logic        slow_pll_on;
        logic        clk_out_on;
        logic        dev_pll_on;
        logic        host_pll_on;
    } seq_state_t;
endpackage

/* dual_port_power_state_sequencer.sv */
// power state sequencer for a combined usb device and host controller, two-port mode
`timescale 1ns/1ps
`include "pwr_seq_defs.svh"

module dual_port_power_state_sequencer
    import pwr_seq_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        rst_b,
    input  wire logic        req_sleep,
    input  wire logic        req_snooze,
    input  wire logic        req_low_clock_active,
    input  wire logic        req_device_active,
    input  wire logic        req_host_active,
    input  wire logic        req_all_active_device_role,
    input  wire logic        req_all_active_host_role,
    input  wire logic        transition_finished_clear,
    input  wire logic        transition_finished_irq_enable,
    input  wire logic [15:0] wake_up_timer,
    input  wire logic        osc_stable_in,
    output logic [6:0]       power_request_reg,
    output logic [3:0]       power_state_field,
    output logic             active_role_indicator,
    output logic             transition_finished_flag,
    output logic             interrupt_out_n,
    output logic             osc_enable,
    output logic             oscillator_clock_gate,
    output logic             slow_pll_enable,
    output logic             system_clock_enable,
    output logic             device_fast_pll_enable,
    output logic             host_fast_pll_enable,
    output logic             device_regs_writable,
    output logic             host_regs_writable,
    output logic             device_transfer_enable,
    output logic             host_transfer_enable
);

    localparam logic [15:0] PLL_SETTLE = 16'(`PLL_SETTLE_CYCLES);
    localparam logic [15:0] STEP       = 16'(`STEP_CYCLES);

    // ------------------------------------------------------------
    // pin synchroniser for the oscillator stable indication
    // ------------------------------------------------------------
    logic osc_sync_a;
    logic osc_sync_b;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            osc_sync_a <= 1'b0;
            osc_sync_b <= 1'b0;
        end else begin
            osc_sync_a <= osc_stable_in;
            osc_sync_b <= osc_sync_a;
        end
    end

    // ------------------------------------------------------------
    // sequencer state
    // ------------------------------------------------------------
    seq_state_t cur;
    seq_state_t next_cur;
    logic [6:0] req_in;
    logic [6:0] new_req;
    logic [3:0] want;
    logic       want_host;
    logic       req_seen;
    logic       wants_fast;
    logic       wants_dev;
    logic       wants_hst;

    // ------------------------------------------------------------
    // request decode
    // ------------------------------------------------------------
    assign req_in = {req_all_active_host_role, req_all_active_device_role,
                     req_host_active, req_device_active, req_low_clock_active,
                     req_snooze, req_sleep};

    // decode lowest set pending bit into a target state
    always_comb begin
        want      = cur.power_state_field;
        want_host = cur.active_role_indicator;
        req_seen  = 1'b0;
        new_req   = cur.pending | req_in;
        if (new_req[0]) begin
            want     = `PSTATE_SLEEP;
            req_seen = 1'b1;
        end else if (new_req[1]) begin
            want     = `PSTATE_SNOOZE;
            req_seen = 1'b1;
        end else if (new_req[2]) begin
            want     = `PSTATE_LOW_CLOCK;
            req_seen = 1'b1;
        end else if (new_req[3]) begin
            want      = `PSTATE_DEVICE;
            want_host = 1'b0;
            req_seen  = 1'b1;
        end else if (new_req[4]) begin
            want      = `PSTATE_HOST;
            want_host = 1'b1;
            req_seen  = 1'b1;
        end else if (new_req[5]) begin
            want      = `PSTATE_ALL;
            want_host = 1'b0;
            req_seen  = 1'b1;
        end else if (new_req[6]) begin
            want      = `PSTATE_ALL;
            want_host = 1'b1;
            req_seen  = 1'b1;
        end
        wants_fast = (cur.target == `PSTATE_DEVICE) || (cur.target == `PSTATE_HOST)
                     || (cur.target == `PSTATE_ALL);
        wants_dev  = (cur.target == `PSTATE_DEVICE) || (cur.target == `PSTATE_ALL);
        wants_hst  = (cur.target == `PSTATE_HOST) || (cur.target == `PSTATE_ALL);
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        next_cur = cur;
        next_cur.pending = cur.pending | req_in;
        if (transition_finished_clear) begin
            next_cur.transition_finished_flag = 1'b0;
        end
        if (cur.count != 16'h0000) begin
            next_cur.count = cur.count - 16'h0001;
        end
        unique case (cur.phase)
            ST_IDLE: begin
                // same-state request other than all-active is left pending and does nothing
                if (req_seen && (want != cur.power_state_field
                                 || want == `PSTATE_ALL)) begin
                    next_cur.target      = want;
                    next_cur.target_host = want_host;
                    next_cur.count       = STEP;
                    if (cur.power_state_field == `PSTATE_ALL && want == `PSTATE_ALL) begin
                        next_cur.phase = ST_FAST_ON;
                    end else if (cur.power_state_field == `PSTATE_SLEEP) begin
                        next_cur.osc_on = 1'b1;
                        next_cur.count  = wake_up_timer;
                        next_cur.phase  = ST_OSC_SETTLE;
                    end else if (cur.power_state_field == `PSTATE_SNOOZE) begin
                        if (want == `PSTATE_SLEEP) begin
                            next_cur.phase = ST_STOP_OSC;
                        end else begin
                            next_cur.slow_pll_on = 1'b1;
                            next_cur.count       = PLL_SETTLE;
                            next_cur.phase       = ST_PLL_SETTLE;
                        end
                    end else if (cur.power_state_field == `PSTATE_LOW_CLOCK) begin
                        if (want == `PSTATE_SNOOZE) begin
                            next_cur.phase = ST_STOP_CLK;
                        end else if (want == `PSTATE_SLEEP) begin
                            next_cur.phase = ST_STOP_SLOW;
                        end else begin
                            next_cur.phase = ST_FAST_ON;
                        end
                    end else begin
                        // on the way to snooze the clock output goes down first
                        next_cur.phase = (want == `PSTATE_SNOOZE)
                                         ? ST_STOP_CLK : ST_STOP_FAST;
                    end
                end
            end
            ST_STOP_FAST: if (cur.count == 16'h0000) begin
                next_cur.dev_pll_on  = 1'b0;
                next_cur.host_pll_on = 1'b0;
                next_cur.power_state_field = `PSTATE_LOW_CLOCK;
                next_cur.count = STEP;
                if (cur.target == `PSTATE_SLEEP || cur.target == `PSTATE_SNOOZE) begin
                    next_cur.phase = ST_STOP_SLOW;
                end else if (cur.target == `PSTATE_LOW_CLOCK) begin
                    next_cur.phase = ST_IDLE;
                end else begin
                    next_cur.phase = ST_FAST_ON;
                end
            end
            ST_STOP_CLK: if (cur.count == 16'h0000) begin
                next_cur.clk_out_on = 1'b0;
                next_cur.count = STEP;
                next_cur.phase = (cur.dev_pll_on || cur.host_pll_on)
                                 ? ST_STOP_FAST : ST_STOP_SLOW;
            end
            ST_STOP_SLOW: if (cur.count == 16'h0000) begin
                next_cur.slow_pll_on = 1'b0;
                // no source left for the system clock once the slow pll stops
                next_cur.clk_out_on = 1'b0;
                next_cur.power_state_field = `PSTATE_SNOOZE;
                next_cur.count = STEP;
                next_cur.phase = (cur.target == `PSTATE_SLEEP) ? ST_STOP_OSC : ST_IDLE;
            end
            ST_STOP_OSC: if (cur.count == 16'h0000) begin
                // oscillator output gated one step before the oscillator halts
                if (cur.osc_clk_gate) begin
                    next_cur.osc_clk_gate = 1'b0;
                    next_cur.count = STEP;
                end else begin
                    next_cur.osc_on = 1'b0;
                    next_cur.power_state_field = `PSTATE_SLEEP;
                    next_cur.phase = ST_IDLE;
                end
            end
            ST_OSC_SETTLE: if (cur.count == 16'h0000 && osc_sync_b) begin
                next_cur.osc_clk_gate = 1'b1;
                next_cur.power_state_field = `PSTATE_SNOOZE;
                if (cur.target == `PSTATE_SNOOZE) begin
                    next_cur.phase = ST_IDLE;
                end else begin
                    next_cur.slow_pll_on = 1'b1;
                    next_cur.count = PLL_SETTLE;
                    next_cur.phase = ST_PLL_SETTLE;
                end
            end
            ST_PLL_SETTLE: if (cur.count == 16'h0000) begin
                next_cur.clk_out_on = 1'b1;
                next_cur.power_state_field = `PSTATE_LOW_CLOCK;
                next_cur.count = STEP;
                next_cur.phase = wants_fast ? ST_FAST_ON : ST_IDLE;
            end
            ST_FAST_ON: if (cur.count == 16'h0000) begin
                next_cur.dev_pll_on  = wants_dev;
                next_cur.host_pll_on = wants_hst;
                next_cur.active_role_indicator = cur.target_host;
                next_cur.power_state_field = cur.target;
                next_cur.phase = ST_IDLE;
            end
            default: next_cur.phase = ST_IDLE;
        endcase
        // completion: flag, consume request
        if (cur.phase != ST_IDLE && next_cur.phase == ST_IDLE) begin
            next_cur.transition_finished_flag = 1'b1;
            next_cur.pending = req_in;
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            cur <= '{phase: ST_IDLE, power_state_field: `PSTATE_SLEEP,
                     target: `PSTATE_SLEEP, count: 16'h0000, default: '0};
        end else begin
            cur <= next_cur;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign power_request_reg        = cur.pending;
    assign power_state_field        = cur.power_state_field;
    assign active_role_indicator    = cur.active_role_indicator;
    assign transition_finished_flag = cur.transition_finished_flag;
    assign interrupt_out_n = ~(cur.transition_finished_flag
                               & transition_finished_irq_enable);
    assign osc_enable             = cur.osc_on;
    assign oscillator_clock_gate  = cur.osc_clk_gate;
    assign slow_pll_enable        = cur.slow_pll_on;
    assign system_clock_enable    = cur.clk_out_on;
    assign device_fast_pll_enable = cur.dev_pll_on;
    assign host_fast_pll_enable   = cur.host_pll_on;

    // ------------------------------------------------------------
    // register permission and transfer role
    // ------------------------------------------------------------
    // register write permission and transfer role; always-on regs are outside this gating
    assign device_regs_writable = (cur.power_state_field == `PSTATE_DEVICE)
                                  || (cur.power_state_field == `PSTATE_ALL);
    assign host_regs_writable   = (cur.power_state_field == `PSTATE_HOST)
                                  || (cur.power_state_field == `PSTATE_ALL);
    assign device_transfer_enable = device_regs_writable & ~cur.active_role_indicator
                                    & (cur.phase == ST_IDLE);
    assign host_transfer_enable   = host_regs_writable & cur.active_role_indicator
                                    & (cur.phase == ST_IDLE);

endmodule

/* pwr_seq_chk.sv */
// assertions on the ports of the power state sequencer
`timescale 1ns/1ps
`include "pwr_seq_defs.svh"
module pwr_seq_chk (
    input wire logic       clock,
    input wire logic       rst_b,
    input wire logic       transition_finished_clear,
    input wire logic       transition_finished_irq_enable,
    input wire logic [3:0] power_state_field,
    input wire logic       active_role_indicator,
    input wire logic       transition_finished_flag,
    input wire logic       interrupt_out_n,
    input wire logic       osc_enable,
    input wire logic       oscillator_clock_gate,
    input wire logic       slow_pll_enable,
    input wire logic       system_clock_enable,
    input wire logic       device_fast_pll_enable,
    input wire logic       host_fast_pll_enable,
    input wire logic       device_transfer_enable,
    input wire logic       host_transfer_enable
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);
    wire       done = transition_finished_flag;
    wire [3:0] st   = power_state_field;
    wire       fast = device_fast_pll_enable | host_fast_pll_enable;
    chk_irq_out: assert property (interrupt_out_n == !(done && transition_finished_irq_enable))
        else $error("interrupt output wrong");
    chk_flag_holds: assert property (done && !transition_finished_clear |=> done)
        else $error("finished flag lost");
    chk_sleep_clk: assert property (done && st == `PSTATE_SLEEP |-> !osc_enable && !slow_pll_enable
        && !fast && !oscillator_clock_gate && !system_clock_enable)
        else $error("clocks running in sleep");
    chk_gate_order: assert property ($fell(oscillator_clock_gate) |->
        osc_enable && !slow_pll_enable && !fast && !system_clock_enable)
        else $error("oscillator output stopped out of order");
    chk_slow_last: assert property ($fell(slow_pll_enable) |-> !fast && !system_clock_enable)
        else $error("slow pll stopped too early");
    chk_low_clk: assert property (done && st == `PSTATE_LOW_CLOCK |-> osc_enable && slow_pll_enable && !fast)
        else $error("wrong clocks in low-clock state");
    chk_dev_role: assert property (done && st == `PSTATE_DEVICE |->
        device_fast_pll_enable && !host_fast_pll_enable && !active_role_indicator)
        else $error("wrong device-active outputs");
    chk_host_role: assert property (done && st == `PSTATE_HOST |->
        host_fast_pll_enable && !device_fast_pll_enable && active_role_indicator)
        else $error("wrong host-active outputs");
    chk_all_one: assert property (done && st == `PSTATE_ALL |->
        device_fast_pll_enable && host_fast_pll_enable && (device_transfer_enable != host_transfer_enable))
        else $error("wrong all-active outputs");
    chk_osc_last: assert property ($fell(osc_enable) |-> !slow_pll_enable && !fast && !system_clock_enable)
        else $error("oscillator stopped too early");
    chk_osc_gate: assert property ($rose(osc_enable) |-> !oscillator_clock_gate [*8])
        else $error("oscillator clock passed too soon");
    chk_pll_gate: assert property ($rose(slow_pll_enable) |-> !system_clock_enable [*8])
        else $error("system clock passed too soon");
endmodule

bind dual_port_power_state_sequencer pwr_seq_chk u_chk (
    .clock(clock), .rst_b(rst_b), .transition_finished_clear(transition_finished_clear),
    .transition_finished_irq_enable(transition_finished_irq_enable),
    .power_state_field(power_state_field), .active_role_indicator(active_role_indicator),
    .transition_finished_flag(transition_finished_flag), .interrupt_out_n(interrupt_out_n),
    .osc_enable(osc_enable), .oscillator_clock_gate(oscillator_clock_gate),
    .slow_pll_enable(slow_pll_enable), .system_clock_enable(system_clock_enable),
    .device_fast_pll_enable(device_fast_pll_enable), .host_fast_pll_enable(host_fast_pll_enable),
    .device_transfer_enable(device_transfer_enable), .host_transfer_enable(host_transfer_enable));

/* dual_port_power_state_sequencer_test.sv */
// self-checking testbench of the power state sequencer
`timescale 1ns/1ps
module dual_port_power_state_sequencer_test;
    typedef struct packed {logic [3:0] fin; logic r; logic [31:0] p; logic [31:0] m;} note_t;
    logic        clock  = 1'b0;
    logic        rst_b  = 1'b0;
    logic [6:0]  req    = 7'h00;
    logic        clr    = 1'b0;
    logic        irq_en = 1'b0;
    logic        osc_ok = 1'b0;
    logic [15:0] wake   = 16'h0010;
    logic [31:0] rnd    = 32'h0000003F;
    logic [31:0] path   = 32'h00000000;
    logic [3:0]  last   = 4'h0;
    logic        lflag  = 1'b0;
    wire  [6:0]  preq;
    wire  [3:0]  pstate;
    wire         role, flag, irq_n, osc_en;
    int          err_total = 0, n_compared = 0, cycles = 0;
    note_t       q[$];
    note_t       nt;

    always #12.5 clock = ~clock;

    dual_port_power_state_sequencer uut (
        .clock(clock), .rst_b(rst_b), .req_sleep(req[0]), .req_snooze(req[1]),
        .req_low_clock_active(req[2]), .req_device_active(req[3]), .req_host_active(req[4]),
        .req_all_active_device_role(req[5]), .req_all_active_host_role(req[6]),
        .transition_finished_clear(clr), .transition_finished_irq_enable(irq_en),
        .wake_up_timer(wake), .osc_stable_in(osc_ok), .power_request_reg(preq),
        .power_state_field(pstate), .active_role_indicator(role),
        .transition_finished_flag(flag), .interrupt_out_n(irq_n), .osc_enable(osc_en),
        .oscillator_clock_gate(), .slow_pll_enable(), .system_clock_enable(),
        .device_fast_pll_enable(), .host_fast_pll_enable(), .device_regs_writable(),
        .host_regs_writable(), .device_transfer_enable(), .host_transfer_enable());

    // oscillator reports stable half a cycle after being enabled
    always @(negedge clock) osc_ok <= osc_en;

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic final_report;
        if (err_total == 0 && n_compared > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    // pulse one request, note the expected outcome, wait, then clear the flag
    task automatic go(input int b, input logic [3:0] f, input logic r, input logic [31:0] p, m);
        int n;
        @(negedge clock);
        rnd = xs(rnd);
        irq_en = rnd[0];
        wake = 16'h0008 + {10'h000, rnd[9:4]};
        req[b] = 1'b1;
        q.push_back({f, r, p, m});
        @(negedge clock);
        req[b] = 1'b0;
        n = 0;
        while (flag !== 1'b1 && n < 20000) begin
            @(negedge clock);
            n++;
        end
        if (n >= 20000) err_total++;
        chk("pending", 32'h0, {25'h0, preq});
        chk("irq_n", {31'h0, !irq_en}, {31'h0, irq_n});
        clr = 1'b1;
        @(negedge clock);
        clr = 1'b0;
    endtask

    // compare state and path of visited states at each completion, role only for states 3 and up, off the launch edge
    always @(negedge clock) begin
        cycles++;
        if (cycles == 80000) begin
            err_total++;
            final_report();
        end
        if (pstate !== last) path = {path[27:0], pstate};
        last = pstate;
        if (flag === 1'b1 && lflag !== 1'b1 && q.size() > 0) begin
            nt = q.pop_front();
            chk("state", {28'h0, nt.fin}, {28'h0, pstate});
            chk("path", nt.p & nt.m, path & nt.m);
            if (nt.fin >= 4'h3) chk("role", {31'h0, nt.r}, {31'h0, role});
            path = 32'h0;
        end
        lflag = flag;
    end

    initial begin
        repeat (2) @(negedge clock);
        rst_b = 1'b1;
        go(2, 4'h2, 1'b0, 32'h12, 32'hFF);
        go(0, 4'h0, 1'b0, 32'h10, 32'hFF);
        go(3, 4'h3, 1'b0, 32'h123, 32'hFFF);
        go(4, 4'h4, 1'b1, 32'h24, 32'hFF);
        go(3, 4'h3, 1'b0, 32'h23, 32'hFF);
        go(0, 4'h0, 1'b0, 32'h210, 32'hFFF);
        go(5, 4'h5, 1'b0, 32'h5, 32'hF);
        go(6, 4'h5, 1'b1, 32'h0, 32'h0);
        go(5, 4'h5, 1'b0, 32'h0, 32'h0);
        go(1, 4'h1, 1'b0, 32'h21, 32'hFF);
        go(0, 4'h0, 1'b0, 32'h0, 32'hF);
        go(1, 4'h1, 1'b0, 32'h1, 32'hF);
        go(2, 4'h2, 1'b0, 32'h2, 32'hF);
        req[2] = 1'b1;
        @(negedge clock);
        req[2] = 1'b0;
        repeat (50) @(negedge clock);
        chk("same state", 32'h22, {26'h0, preq[2], flag, pstate});
        chk("notes left", 32'h0, q.size());
        final_report();
    end
endmodule
